// ===== logic/dubp_pkg.sv
/*
 Constants and types shared by the two ends of the dual-channel host bus port.
 Assumes one 100 MHz clock with a synchronous active-high reset on both ends.
*/
// Contract
// [R1] Three select lines pick channel register
// [R2] Eight-bit two-way data bus
// [R3] Read strobe fall fetches addressed register
// [R4] Host captures read byte at strobe rise
// [R5] Write strobe fall starts internal write
// [R6] Write strobe rise loads bus byte
// [R7] Channel answers only while selected
// [R8] Bit3 set: drive irq, gp output low
// [R9] Bit3 clear: irq floats, gp high; default 0
// [R10] Channel B gates its outputs likewise
// [R11] Channel A serial data on own pin
// [R12] Far end idles serial input high
// [R13] Request-to-send output, software controlled
// [R14] Clear-to-send only readable, no effect
// [R15] Data driven only during selected read
package dubp_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 8;
    localparam logic [2:0] MODEM_CTRL_ADDR = 3'h4;
    localparam logic [2:0] MSR_ADDR = 3'h6;
    localparam logic [2:0] GPR_ADDR = 3'h7;
    localparam int MODEM_CTRL_RTS_BIT = 1;
    localparam int MODEM_CTRL_IRQ_EN_BIT = 3;
    localparam int MODEM_CTRL_TX_BIT = 0;
    localparam int MSR_CTS_BIT = 4;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int STROBE_CYCLES = 4;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        DUBP_IDLE = 2'b00,
        DUBP_ASSERT = 2'b01,
        DUBP_HOLD = 2'b11,
        DUBP_DONE = 2'b10
    } dubp_state_t;
endpackage : dubp_pkg

// ===== logic/dubp_if.sv
/*
 Pin-level carrier between host end and device end.
 Resolves the data bus here from the enables; assumes the bench reads the interrupt lines with their enables.
*/
`timescale 1ns/1ps
interface dubp_if;
    logic [2:0] reg_select;
    logic read_strobe_n;
    logic write_strobe_n;
    logic chan_a_select_n;
    logic chan_b_select_n;
    logic [7:0] host_data;
    logic host_data_oe_n;
    logic [7:0] dev_data;
    logic dev_data_oe_n;
    logic [7:0] bus_data;
    logic chan_a_irq;
    logic chan_a_irq_oe_n;
    logic chan_b_irq;
    logic chan_b_irq_oe_n;
    logic chan_a_gp_out_n;
    logic chan_b_gp_out_n;
    // Resolved bus level, no contention check
    assign bus_data = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 8'hFF);
    modport host (
        output reg_select, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
        output host_data, host_data_oe_n,
        input bus_data, chan_a_irq, chan_a_irq_oe_n, chan_b_irq, chan_b_irq_oe_n,
        input chan_a_gp_out_n, chan_b_gp_out_n
    );
    modport device (
        input reg_select, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
        input bus_data,
        output dev_data, dev_data_oe_n,
        output chan_a_irq, chan_a_irq_oe_n, chan_b_irq, chan_b_irq_oe_n,
        output chan_a_gp_out_n, chan_b_gp_out_n
    );
endinterface : dubp_if

// ===== logic/dubp_device.sv
/*
 Device end: two channels of eight byte registers behind an
 asynchronous strobe bus, with irq gating and channel A modem pins.
 Assumes bus pins come from outside the clock domain and are synchronised here.
*/
`timescale 1ns/1ps
module dubp_device (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Host bus pins
    dubp_if.device bus,
    // Channel event sources
    input wire logic i_chan_a_event,
    input wire logic i_chan_b_event,
    // Channel A modem pins
    input wire logic i_chan_a_serial_in,
    input wire logic i_chan_a_clear_send_n,
    output logic o_chan_a_serial_out,
    output logic o_chan_a_req_send_n,
    // Write notification
    output logic o_write_pulse,
    output logic [dubp_pkg::ADDR_W-1:0] o_write_addr,
    output logic o_write_chan_b
);
    import dubp_pkg::*;

    logic [4:0] meta_ff, sync_ff;
    logic [7:0] dmeta_ff, dsync_ff;
    logic [1:0] serin_meta_ff, serin_ff;
    logic [7:0] regs_a_ff [NUM_REGS];
    logic [7:0] regs_b_ff [NUM_REGS];
    logic [7:0] nxt_regs_a [NUM_REGS];
    logic [7:0] nxt_regs_b [NUM_REGS];
    logic rd_prev_ff, wr_prev_ff, nxt_rd_prev, nxt_wr_prev;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [2:0] waddr_ff, nxt_waddr;
    logic wsel_a_ff, wsel_b_ff, nxt_wsel_a, nxt_wsel_b;
    logic wpulse_ff, nxt_wpulse;
    logic wchan_b_ff, nxt_wchan_b;
    logic [2:0] s_addr;
    logic s_rd_n, s_wr_n, s_csa_n, s_csb_n, s_cts_n;

    // Two-flop synchronisers for all pins
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            meta_ff <= 5'h1F;
            sync_ff <= 5'h1F;
            dmeta_ff <= 8'h00;
            dsync_ff <= 8'h00;
            serin_meta_ff <= 2'h3;
            serin_ff <= 2'h3;
        end else begin
            meta_ff <= {bus.reg_select, bus.read_strobe_n, bus.write_strobe_n};
            sync_ff <= meta_ff;
            dmeta_ff <= bus.bus_data;
            dsync_ff <= dmeta_ff;
            serin_meta_ff <= {i_chan_a_serial_in, i_chan_a_clear_send_n};
            serin_ff <= serin_meta_ff;
        end
    end

    logic [1:0] cs_meta_ff, cs_ff;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cs_meta_ff <= 2'h3;
            cs_ff <= 2'h3;
        end else begin
            cs_meta_ff <= {bus.chan_b_select_n, bus.chan_a_select_n};
            cs_ff <= cs_meta_ff;
        end
    end

    assign s_addr = sync_ff[4:2]; // [R1]
    assign s_rd_n = sync_ff[1];
    assign s_wr_n = sync_ff[0];
    assign s_csa_n = cs_ff[0];
    assign s_csb_n = cs_ff[1];
    assign s_cts_n = serin_ff[0];

    function automatic logic [7:0] rd_mux(input logic [7:0] r, input logic [2:0] a, input logic cts_n);
        logic [7:0] v;
        v = r;
        if (a == MSR_ADDR) begin
            v[MSR_CTS_BIT] = ~cts_n; // [R14]
        end
        return v;
    endfunction : rd_mux

    always_comb begin
        nxt_regs_a = regs_a_ff;
        nxt_regs_b = regs_b_ff;
        nxt_rd_prev = s_rd_n;
        nxt_wr_prev = s_wr_n;
        nxt_rdata = rdata_ff;
        nxt_waddr = waddr_ff;
        nxt_wsel_a = wsel_a_ff;
        nxt_wsel_b = wsel_b_ff;
        nxt_wpulse = 1'b0;
        nxt_wchan_b = wchan_b_ff;
        // Read fetch at strobe fall
        if (rd_prev_ff && !s_rd_n) begin // [R3]
            if (!s_csa_n) begin // [R7]
                nxt_rdata = rd_mux(regs_a_ff[s_addr], s_addr, s_cts_n);
            end else if (!s_csb_n) begin
                nxt_rdata = regs_b_ff[s_addr];
            end
        end
        // Write target latched at strobe fall
        if (wr_prev_ff && !s_wr_n) begin // [R5]
            nxt_waddr = s_addr;
            nxt_wsel_a = !s_csa_n; // [R7]
            nxt_wsel_b = s_csa_n && !s_csb_n;
        end
        // Byte loaded at strobe rise
        if (!wr_prev_ff && s_wr_n) begin // [R6]
            if (wsel_a_ff) begin
                nxt_regs_a[waddr_ff] = dsync_ff;
            end
            if (wsel_b_ff) begin
                nxt_regs_b[waddr_ff] = dsync_ff;
            end
            nxt_wpulse = wsel_a_ff || wsel_b_ff;
            nxt_wchan_b = wsel_b_ff;
            nxt_wsel_a = 1'b0;
            nxt_wsel_b = 1'b0;
        end
        // Status byte shows channel events, event beats a clearing write
        nxt_regs_a[GPR_ADDR][0] = nxt_regs_a[GPR_ADDR][0] | i_chan_a_event;
        nxt_regs_b[GPR_ADDR][0] = nxt_regs_b[GPR_ADDR][0] | i_chan_b_event;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_a_ff[i] <= REG_RST; // [R9]
                regs_b_ff[i] <= REG_RST;
            end
            rd_prev_ff <= 1'b1;
            wr_prev_ff <= 1'b1;
            rdata_ff <= 8'h00;
            waddr_ff <= 3'h0;
            wsel_a_ff <= 1'b0;
            wsel_b_ff <= 1'b0;
            wpulse_ff <= 1'b0;
            wchan_b_ff <= 1'b0;
        end else begin
            regs_a_ff <= nxt_regs_a;
            regs_b_ff <= nxt_regs_b;
            rd_prev_ff <= nxt_rd_prev;
            wr_prev_ff <= nxt_wr_prev;
            rdata_ff <= nxt_rdata;
            waddr_ff <= nxt_waddr;
            wsel_a_ff <= nxt_wsel_a;
            wsel_b_ff <= nxt_wsel_b;
            wpulse_ff <= nxt_wpulse;
            wchan_b_ff <= nxt_wchan_b;
        end
    end

    // Bus driven only within a selected read
    assign bus.dev_data = rdata_ff; // [R2]
    assign bus.dev_data_oe_n = !(!rd_prev_ff && !s_rd_n && (!s_csa_n || !s_csb_n)); // [R15]
    assign bus.chan_a_irq = regs_a_ff[GPR_ADDR][0];
    assign bus.chan_a_irq_oe_n = !regs_a_ff[MODEM_CTRL_ADDR][MODEM_CTRL_IRQ_EN_BIT]; // [R8]
    assign bus.chan_a_gp_out_n = !regs_a_ff[MODEM_CTRL_ADDR][MODEM_CTRL_IRQ_EN_BIT]; // [R9]
    assign bus.chan_b_irq = regs_b_ff[GPR_ADDR][0];
    assign bus.chan_b_irq_oe_n = !regs_b_ff[MODEM_CTRL_ADDR][MODEM_CTRL_IRQ_EN_BIT]; // [R10]
    assign bus.chan_b_gp_out_n = !regs_b_ff[MODEM_CTRL_ADDR][MODEM_CTRL_IRQ_EN_BIT]; // [R10]
    // Serial line idles high until software drives it
    assign o_chan_a_serial_out = !regs_a_ff[MODEM_CTRL_ADDR][MODEM_CTRL_TX_BIT]; // [R11]
    assign o_chan_a_req_send_n = !regs_a_ff[MODEM_CTRL_ADDR][MODEM_CTRL_RTS_BIT]; // [R13]
    assign o_write_pulse = wpulse_ff;
    assign o_write_addr = waddr_ff;
    assign o_write_chan_b = wchan_b_ff;
endmodule : dubp_device

// ===== logic/dubp_host.sv
/*
 Host end: turns one-cycle read/write requests into strobe bus cycles.
 Assumes the device synchronises pins; strobe phases last STROBE_CYCLES.
*/
`timescale 1ns/1ps
module dubp_host (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Request port
    input wire logic i_req,
    input wire logic i_write,
    input wire logic i_chan_b,
    input wire logic [dubp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dubp_pkg::DATA_W-1:0] i_wdata,
    output logic o_ready,
    output logic o_done,
    output logic [dubp_pkg::DATA_W-1:0] o_rdata,
    // Device pins
    dubp_if.host bus
);
    import dubp_pkg::*;

    dubp_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr, chb_ff, nxt_chb, done_ff, nxt_done;
    logic [2:0] addr_ff, nxt_addr;
    logic [7:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [7:0] dmeta_ff, dsync_ff;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            dmeta_ff <= 8'h00;
            dsync_ff <= 8'h00;
        end else begin
            dmeta_ff <= bus.bus_data;
            dsync_ff <= dmeta_ff;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_wr = wr_ff;
        nxt_chb = chb_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_done = 1'b0;
        case (state_ff)
            DUBP_IDLE: begin
                if (i_req) begin
                    nxt_state = DUBP_ASSERT;
                    nxt_wr = i_write;
                    nxt_chb = i_chan_b;
                    nxt_addr = i_addr;
                    nxt_wdata = i_wdata;
                    nxt_cnt = 4'h0;
                end
            end
            DUBP_ASSERT: begin
                // Select and address settle before strobe
                nxt_state = DUBP_HOLD;
                nxt_cnt = 4'h0;
            end
            DUBP_HOLD: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == 4'(STROBE_CYCLES - 1)) begin
                    nxt_state = DUBP_DONE;
                    nxt_cnt = 4'h0;
                end
            end
            DUBP_DONE: begin
                // Pin byte seen at strobe rise leaves the synchroniser here
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == 4'(SYNC_STAGES - 1)) begin
                    nxt_state = DUBP_IDLE;
                    nxt_done = 1'b1;
                    if (!wr_ff) begin
                        nxt_rdata = dsync_ff; // [R4]
                    end
                end
            end
            default: nxt_state = DUBP_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_ff <= DUBP_IDLE;
            cnt_ff <= 4'h0;
            wr_ff <= 1'b0;
            chb_ff <= 1'b0;
            addr_ff <= 3'h0;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            chb_ff <= nxt_chb;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            done_ff <= nxt_done;
        end
    end

    logic active, strobe;
    assign active = state_ff != DUBP_IDLE;
    assign strobe = state_ff == DUBP_HOLD;
    assign bus.reg_select = addr_ff; // [R1]
    assign bus.chan_a_select_n = !(active && !chb_ff); // [R7]
    assign bus.chan_b_select_n = !(active && chb_ff);
    assign bus.read_strobe_n = !(strobe && !wr_ff);
    assign bus.write_strobe_n = !(strobe && wr_ff);
    // Data held through the write strobe rise
    assign bus.host_data = wdata_ff; // [R6]
    assign bus.host_data_oe_n = !(active && wr_ff); // [R2]
    assign o_ready = !active;
    assign o_done = done_ff;
    assign o_rdata = rdata_ff;
endmodule : dubp_host

// ===== dv/dubp_props.sv
/*
 Pin checks between the host end and the device end.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dubp_props (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Bus pins
    input wire logic [2:0] reg_select,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic [7:0] host_data,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic chan_a_irq_oe_n,
    input wire logic chan_b_irq_oe_n,
    input wire logic chan_a_gp_out_n,
    input wire logic chan_b_gp_out_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence wr_phase;
        !write_strobe_n[*4] ##1 write_strobe_n;
    endsequence
    sequence rd_phase;
        !read_strobe_n[*4] ##1 read_strobe_n;
    endsequence
    wr_len_a: assert property ($fell(write_strobe_n) |-> wr_phase)
        else $error("write strobe length wrong");
    rd_len_a: assert property ($fell(read_strobe_n) |-> rd_phase)
        else $error("read strobe length wrong");
    rd_drive_a: assert property ($fell(read_strobe_n) |-> ##[1:4] !dev_data_oe_n)
        else $error("read data never driven");
    bus_float_a: assert property (!dev_data_oe_n |-> !$past(read_strobe_n) || !$past(read_strobe_n, 2)
        || !$past(read_strobe_n, 3) || !$past(read_strobe_n, 4)) else $error("data driven outside read");
    addr_hold_a: assert property (!(read_strobe_n && write_strobe_n) |=>
        (read_strobe_n && write_strobe_n) || $stable(reg_select)) else $error("select lines moved");
    sel_gate_a: assert property (!(read_strobe_n && write_strobe_n) |->
        !chan_a_select_n || !chan_b_select_n) else $error("strobe without channel select");
    data_hold_a: assert property (!write_strobe_n |=>
        write_strobe_n || ($stable(host_data) && !host_data_oe_n)) else $error("write data moved");
    host_rd_a: assert property (!host_data_oe_n |-> read_strobe_n)
        else $error("host drives during read");
    gate_a_a: assert property (chan_a_gp_out_n == chan_a_irq_oe_n)
        else $error("channel A gating mismatch");
    gate_b_a: assert property (chan_b_gp_out_n == chan_b_irq_oe_n)
        else $error("channel B gating mismatch");
    gp_reset_a: assert property ($fell(i_reset) |-> chan_a_gp_out_n && chan_b_gp_out_n)
        else $error("gp output low after reset");
endmodule : dubp_props

// ===== dv/dubp_tb.sv
/*
 Bench joining host end and device end through the pin carrier.
 Assumes a 100 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dubp_tb;
    import dubp_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_req = 1'b0;
    logic i_write = 1'b0;
    logic i_chan_b = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic ev_a = 1'b0;
    logic ev_b = 1'b0;
    logic cts_n = 1'b1;
    logic o_ready, o_done, ser_out, rts_n, wr_pulse, wr_chan_b;
    logic [7:0] o_rdata;
    logic [2:0] wr_addr;
    logic [2:0] a;
    logic [7:0] mem [0:15];
    logic [15:0] lfsr = 16'h2040;
    int err_count = 0;
    int samples_checked = 0;
    dubp_if bus_if ();
    dubp_host dubp_host_i (.i_clock(i_clock), .i_reset(i_reset), .i_req(i_req), .i_write(i_write),
        .i_chan_b(i_chan_b), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done),
        .o_rdata(o_rdata), .bus(bus_if));
    dubp_device dubp_device_i (.i_clock(i_clock), .i_reset(i_reset), .bus(bus_if), .i_chan_a_event(ev_a),
        .i_chan_b_event(ev_b), .i_chan_a_serial_in(1'b1), .i_chan_a_clear_send_n(cts_n),
        .o_chan_a_serial_out(ser_out), .o_chan_a_req_send_n(rts_n), .o_write_pulse(wr_pulse),
        .o_write_addr(wr_addr), .o_write_chan_b(wr_chan_b));
    dubp_props dubp_props_i (.i_clock(i_clock), .i_reset(i_reset), .reg_select(bus_if.reg_select),
        .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .chan_a_select_n(bus_if.chan_a_select_n), .chan_b_select_n(bus_if.chan_b_select_n),
        .host_data(bus_if.host_data), .host_data_oe_n(bus_if.host_data_oe_n),
        .dev_data_oe_n(bus_if.dev_data_oe_n), .chan_a_irq_oe_n(bus_if.chan_a_irq_oe_n),
        .chan_b_irq_oe_n(bus_if.chan_b_irq_oe_n), .chan_a_gp_out_n(bus_if.chan_a_gp_out_n),
        .chan_b_gp_out_n(bus_if.chan_b_gp_out_n));
    always #5 i_clock = ~i_clock;
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic xfer(input logic w, input logic cb, input logic [2:0] ad, input logic [7:0] d);
        int n;
        bit dn;
        bit pl;
        n = 0;
        dn = 1'b0;
        pl = !w;
        @(negedge i_clock);
        check({7'h0, o_ready}, 8'h01);
        @(posedge i_clock);
        i_req <= 1'b1;
        i_write <= w;
        i_chan_b <= cb;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_clock);
        i_req <= 1'b0;
        while (!(dn && pl) && n < 60) begin
            @(negedge i_clock);
            n++;
            dn |= (o_done === 1'b1);
            pl |= (wr_pulse === 1'b1);
        end
        if (n >= 60) begin
            err_count++;
            $display("[FAIL] %0t request timed out", $time);
            test_done();
        end
        repeat (2) @(negedge i_clock);
        if (w) mem[{cb, ad}] = d;
    endtask : xfer
    task automatic pins_check();
        check({7'h0, ser_out}, {7'h0, ~mem[{1'b0, MODEM_CTRL_ADDR}][MODEM_CTRL_TX_BIT]});
        check({7'h0, rts_n}, {7'h0, ~mem[{1'b0, MODEM_CTRL_ADDR}][MODEM_CTRL_RTS_BIT]});
        check({7'h0, bus_if.chan_a_gp_out_n}, {7'h0, ~mem[{1'b0, MODEM_CTRL_ADDR}][MODEM_CTRL_IRQ_EN_BIT]});
        check({7'h0, bus_if.chan_b_gp_out_n}, {7'h0, ~mem[{1'b1, MODEM_CTRL_ADDR}][MODEM_CTRL_IRQ_EN_BIT]});
    endtask : pins_check
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'h00;
        repeat (8) @(posedge i_clock);
        i_reset <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            xfer(1'b0, i[3], i[2:0], 8'h00);
            check(o_rdata, 8'h00);
        end
        xfer(1'b1, 1'b0, MODEM_CTRL_ADDR, 8'hFF);
        pins_check();
        for (int k = 0; k < 60; k++) begin
            lfsr = lfsr_next(lfsr);
            a = (lfsr[2:0] > 3'h5) ? MODEM_CTRL_ADDR : lfsr[2:0];
            xfer(lfsr[4], lfsr[3], a, lfsr[15:8]);
            if (lfsr[4]) begin
                check({4'h0, wr_chan_b, wr_addr}, {4'h0, lfsr[3], a});
                pins_check();
            end else begin
                check(o_rdata, mem[{lfsr[3], a}]);
            end
        end
        for (int c = 0; c < 2; c++) begin
            xfer(1'b1, c[0], MODEM_CTRL_ADDR, 8'h08);
            @(posedge i_clock);
            ev_a <= (c == 0);
            ev_b <= (c == 1);
            repeat (4) @(posedge i_clock);
            ev_a <= 1'b0;
            ev_b <= 1'b0;
            xfer(1'b0, c[0], GPR_ADDR, 8'h00);
            check(o_rdata & 8'h01, 8'h01);
            check({6'h0, c ? {bus_if.chan_b_irq, bus_if.chan_b_irq_oe_n} :
                {bus_if.chan_a_irq, bus_if.chan_a_irq_oe_n}}, 8'h02);
            xfer(1'b1, c[0], GPR_ADDR, 8'h00);
            xfer(1'b0, c[0], GPR_ADDR, 8'h00);
            check(o_rdata & 8'h01, 8'h00);
            xfer(1'b1, c[0], MODEM_CTRL_ADDR, 8'h00);
            check({7'h0, c ? bus_if.chan_b_irq_oe_n : bus_if.chan_a_irq_oe_n}, 8'h01);
        end
        for (int v = 0; v < 2; v++) begin
            @(posedge i_clock);
            cts_n <= v[0];
            repeat (4) @(posedge i_clock);
            xfer(1'b0, 1'b0, MSR_ADDR, 8'h00);
            check(o_rdata & 8'h10, v ? 8'h00 : 8'h10);
            pins_check();
        end
        test_done();
    end
endmodule : dubp_tb
